/* core/uaf_top.sv */
// Serial port with address-filtering receiver, APB register slave
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module uaf_top (
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        rxd_in,
   output logic             txd_out
);
   typedef struct packed {
      logic            rdy;
      logic            err;
      logic [31:0]     rdata;
      logic            afm;
      logic            dbl;
      logic            txc;
      logic            rxen;
      logic            txen;
      logic            usbs;
      logic            tb8;
      logic [2:0]      sz;
      logic [1:0]      upm;
      logic [11:0]     baud;
      logic            dor;
      logic            s1;
      logic            s2;
      logic            s3;
      logic            lvl;
      logic [11:0]     bcnt;
      uaf_pkg::uaf_rx_e st;
      logic [4:0]      smp;
      logic [3:0]      bit_i;
      logic [1:0]      v;
      logic [10:0]     sh;
      logic [1:0]      wp;
      logic [1:0]      rp;
      logic [8:0]      tbuf;
      logic            tfull;
      logic            tbusy;
      logic [12:0]     tsh;
      logic [3:0]      tleft;
      logic [4:0]      tsmp;
      logic            txd;
   } uaf_state_s;

   uaf_state_s  r;
   uaf_state_s  next_r;
   logic [10:0] head;
   logic        nine;
   logic [3:0]  nd;
   logic        pen;
   logic [3:0]  nbits;
   logic [4:0]  spb;
   logic [4:0]  sf;
   logic        tick;
   logic        maj;
   logic        decide;
   logic        done;
   logic [10:0] fr;
   logic [8:0]  dmask;
   logic [8:0]  data9;
   logic        ftype;
   logic        perr;
   logic        drop;
   logic        full;
   logic        empty;
   logic        mem_we;
   logic        acc;
   logic        tload;
   logic [8:0]  td;
   logic [12:0] tfr;
   logic        txc_set;
   logic [7:0]  csra;

   // Character size is one setting for both directions
   assign nine  = r.sz == uaf_pkg::SZ_NINE;
   assign nd    = nine ? 4'd9 : uaf_pkg::MIN_BITS + {2'b00, r.sz[1:0]};
   assign pen   = r.upm[1];
   assign nbits = nd + {3'b000, pen} + 4'd1;
   assign dmask = ~(9'h1ff << nd);

   // Samples per bit and centred vote window follow the speed mode
   assign spb   = r.dbl ? uaf_pkg::SPB_DBL : uaf_pkg::SPB_NORM;
   assign sf    = r.dbl ? uaf_pkg::FIRST_DBL : uaf_pkg::FIRST_NORM;
   assign tick  = r.bcnt == 12'h000;

   // Majority of the two held samples and the current one
   assign maj    = (r.v[0] & r.v[1]) | (r.v[0] & r.lvl) | (r.v[1] & r.lvl);
   assign decide = tick && (r.st != uaf_pkg::UAF_IDLE) && (r.smp == sf + 5'd2);
   assign done   = decide && (r.st == uaf_pkg::UAF_BITS) && (r.bit_i == nbits - 4'd1);

   // Frame as received, stop bit merged in
   assign fr    = r.sh | (11'(maj) << (nbits - 4'd1));
   assign data9 = fr[8:0] & dmask;
   assign ftype = nine ? fr[8] : maj;
   assign perr  = pen & (fr[nd] ^ (^data9) ^ r.upm[0]);
   assign drop  = r.afm & ~ftype;

   // Buffer occupancy from wrap-extended pointers
   assign full   = (r.wp ^ r.rp) == 2'b10;
   assign empty  = r.wp == r.rp;
   assign mem_we = done && !drop && !full && r.rxen;

   // Bus access completes on the cycle pready is high
   assign acc = psel_in && penable_in && r.rdy;

   // Transmit frame: start, data, optional parity, stop ones above
   assign tload = tick && !r.tbusy && r.tfull && r.txen;
   assign td    = r.tbuf & dmask;
   assign tfr   = (13'h1fff << (nd + 4'd1 + {3'b000, pen})) | {3'b000, td, 1'b0}
                  | (13'(pen & ((^td) ^ r.upm[0])) << (nd + 4'd1));
   assign txc_set = tick && r.tbusy && (r.tsmp == spb) && (r.tleft == 4'd0) && !r.tfull;

   // Status seen by software; frame and parity error flags follow the buffer head, overrun flag is held in its own register
   assign csra = {~empty, r.txc, ~r.tfull, ~empty & head[9], r.dor,
                  ~empty & head[10], r.dbl, r.afm};

   uaf_rx_mem #(
      .W     (11),
      .DEPTH (2),
      .AW    (1)
   ) u_mem (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .we_in     (mem_we),
      .waddr_in  (r.wp[0]),
      .wdata_in  ({perr, ~maj, data9}),
      .raddr_in  (r.rp[0]),
      .rdata_out (head)
   );

   // Next state of the whole block
   always_comb begin
      next_r = r;
      // Line synchroniser, a change counts when stages two and three agree
      next_r.s1 = rxd_in;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.lvl = r.s3;
      end
      // Sample clock divider
      next_r.bcnt = tick ? r.baud : r.bcnt - 12'h001;

      // Bus slave: data prepared one cycle ahead of pready
      next_r.rdy = psel_in && penable_in && !r.rdy;
      next_r.err = 1'b0;
      if (psel_in && penable_in && !r.rdy) begin
         next_r.rdata = 32'h0000_0000;
         if (paddr_in == uaf_pkg::ADDR_CSRA) begin
            next_r.rdata[7:0] = csra;
         end else if (paddr_in == uaf_pkg::ADDR_CSRB) begin
            // Ninth bit readable before the data pop
            next_r.rdata[7:0] = {3'b000, r.rxen, r.txen, r.sz[2], ~empty & head[8], r.tb8};
         end else if (paddr_in == uaf_pkg::ADDR_CSRC) begin
            next_r.rdata[7:0] = {2'b00, r.upm, r.usbs, r.sz[1:0], 1'b0};
         end else if (paddr_in == uaf_pkg::ADDR_BAUD) begin
            next_r.rdata[11:0] = r.baud;
         end else if (paddr_in == uaf_pkg::ADDR_DATA) begin
            next_r.rdata[7:0] = empty ? 8'h00 : head[7:0];
         end else begin
            next_r.err = 1'b1;
         end
      end

      // Register writes and read side effects
      if (acc && pwrite_in) begin
         if (paddr_in == uaf_pkg::ADDR_CSRA) begin
            // Shared location: writing one here clears the flag
            next_r.afm = pwdata_in[uaf_pkg::A_AFM];
            next_r.dbl = pwdata_in[uaf_pkg::A_DBL];
            if (pwdata_in[uaf_pkg::A_TXC]) begin
               next_r.txc = 1'b0;
            end
         end else if (paddr_in == uaf_pkg::ADDR_CSRB) begin
            next_r.rxen  = pwdata_in[uaf_pkg::B_RXEN];
            next_r.txen  = pwdata_in[uaf_pkg::B_TXEN];
            next_r.sz[2] = pwdata_in[uaf_pkg::B_SZ2];
            next_r.tb8   = pwdata_in[uaf_pkg::B_TB8];
         end else if (paddr_in == uaf_pkg::ADDR_CSRC) begin
            next_r.upm     = pwdata_in[uaf_pkg::C_UPM +: 2];
            next_r.usbs    = pwdata_in[uaf_pkg::C_USBS];
            next_r.sz[1:0] = pwdata_in[uaf_pkg::C_SZ +: 2];
         end else if (paddr_in == uaf_pkg::ADDR_BAUD) begin
            next_r.baud = pwdata_in[11:0];
         end else if (paddr_in == uaf_pkg::ADDR_DATA) begin
            // Writes while the buffer is occupied are ignored
            if (!r.tfull) begin
               next_r.tbuf  = {r.tb8, pwdata_in[7:0]};
               next_r.tfull = 1'b1;
            end
         end
      end else if (acc && (paddr_in == uaf_pkg::ADDR_DATA) && !empty) begin
         next_r.rp = r.rp + 2'd1;
      end

      // Receiver, one step per sample tick
      if (tick) begin
         case (r.st)
            uaf_pkg::UAF_IDLE: begin
               if (r.rxen && !r.lvl) begin
                  next_r.st  = uaf_pkg::UAF_START;
                  next_r.smp = 5'd1;
                  next_r.sh  = 11'h000;
               end
            end
            default: begin
               next_r.smp = (r.smp == spb) ? 5'd1 : r.smp + 5'd1;
               if (r.smp >= sf && r.smp < sf + 5'd2) begin
                  next_r.v = {r.v[0], r.lvl};
               end
               if (r.st == uaf_pkg::UAF_START) begin
                  // Majority high means a spike, not a start bit
                  if (decide && maj) begin
                     next_r.st = uaf_pkg::UAF_IDLE;
                  end else if (r.smp == spb) begin
                     next_r.st    = uaf_pkg::UAF_BITS;
                     next_r.bit_i = 4'd0;
                  end
               end else if (decide) begin
                  next_r.sh[r.bit_i] = maj;
                  if (done) begin
                     // Idle right after the vote so an early start is caught
                     next_r.st = uaf_pkg::UAF_IDLE;
                     // A frame ending as the receiver is disabled is lost, not counted
                     if (!drop && r.rxen) begin
                        next_r.dor = full;
                        if (!full) begin
                           next_r.wp = r.wp + 2'd1;
                        end
                     end
                  end
               end else if (r.smp == spb) begin
                  next_r.bit_i = r.bit_i + 4'd1;
               end
            end
         endcase
      end

      // Disabling the receiver flushes the buffer and its flags
      if (!r.rxen) begin
         next_r.st  = uaf_pkg::UAF_IDLE;
         next_r.rp  = r.wp;
         next_r.dor = 1'b0;
      end

      // Transmitter, no dependence on the filter mode
      if (tload) begin
         next_r.tsh   = tfr >> 1;
         next_r.txd   = 1'b0;
         next_r.tleft = nd + {3'b000, pen} + {3'b000, r.usbs} + 4'd1; // Stops included
         next_r.tsmp  = 5'd1;
         next_r.tbusy = 1'b1;
         next_r.tfull = 1'b0;
      end else if (tick && r.tbusy) begin
         if (r.tsmp != spb) begin
            next_r.tsmp = r.tsmp + 5'd1;
         end else if (r.tleft == 4'd0) begin
            next_r.tbusy = 1'b0;
            next_r.txd   = 1'b1;
         end else begin
            next_r.tsmp  = 5'd1;
            next_r.txd   = r.tsh[0];
            next_r.tsh   = r.tsh >> 1;
            next_r.tleft = r.tleft - 4'd1;
         end
      end
      // Hardware set beats a software clear in the same cycle
      if (txc_set) begin
         next_r.txc = 1'b1;
      end
   end

   // State register with constant reset values
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r      <= '0;
         r.sz   <= uaf_pkg::RST_SZ;
         r.baud <= uaf_pkg::RST_BAUD;
         r.s1   <= 1'b1;
         r.s2   <= 1'b1;
         r.s3   <= 1'b1;
         r.lvl  <= 1'b1;
         r.txd  <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata_out  = r.rdata;
   assign pready_out  = r.rdy;
   assign pslverr_out = r.err;
   assign txd_out     = r.txd;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   discard_data_a: assert property (done && drop |=> r.wp == $past(r.wp))
      else $error("data frame entered the buffer in filter mode");
   flags_kept_a: assert property (done && drop && r.rxen |=> $stable(r.dor))
      else $error("discarded frame changed overrun flag");
   stop_type_a: assert property (done && !nine |-> ftype == fr[nbits - 4'd1])
      else $error("short frame type not taken from stop bit");
   ninth_type_a: assert property (done && nine |-> ftype == data9[8])
      else $error("nine bit frame type not taken from ninth bit");
   addr_keep_a: assert property (done && ftype && !full && r.rxen
      |=> (r.wp == 2'($past(r.wp) + 2'd1)) && csra[uaf_pkg::A_RXC])
      else $error("address frame not buffered");
   first_vote_a: assert property (tick && r.st != uaf_pkg::UAF_IDLE
      && r.smp == (r.dbl ? uaf_pkg::FIRST_DBL : uaf_pkg::FIRST_NORM)
      |=> r.v[0] == $past(r.lvl))
      else $error("first vote sample missed");
   mid_vote_a: assert property (decide
      |-> r.smp == (r.dbl ? uaf_pkg::MID_DBL : uaf_pkg::MID_NORM) + 5'd1)
      else $error("vote taken at wrong sample");
   bit_len_a: assert property (tick && r.st != uaf_pkg::UAF_IDLE
      && r.smp == (r.dbl ? uaf_pkg::SPB_DBL : uaf_pkg::SPB_NORM) |=> r.smp == 5'd1)
      else $error("bit period length wrong");
   samp_range_a: assert property (r.st != uaf_pkg::UAF_IDLE |-> r.smp <= spb)
      else $error("sample count beyond bit period");
   txc_w1c_a: assert property (acc && pwrite_in && paddr_in == uaf_pkg::ADDR_CSRA
      && pwdata_in[uaf_pkg::A_TXC] && !txc_set |=> !r.txc && r.afm == $past(pwdata_in[0]))
      else $error("transmit complete clear or filter write failed");
   tx_size_a: assert property (tload
      |=> r.tleft == 4'($past(nbits) + {3'b000, $past(r.usbs)}) && !r.txd)
      else $error("transmit length not from shared size");
   bus_ready_a: assert property (psel_in && penable_in && !r.rdy |=> r.rdy ##1 !r.rdy)
      else $error("bus answer not one cycle");

   cover_addr_c: cover property (done && !drop && ftype && r.afm);
   cover_drop_c: cover property (done && drop);
   cover_ovr_c: cover property (done && !drop && full);
   cover_txc_c: cover property (txc_set);
endmodule : uaf_top

/* core/uaf_pkg.sv */
// Constants and types shared by the address-filtering serial port block
// What this block does
// - In address filter mode, frames typed as data never reach the receive buffer.
// - Transmitter behaves identically whatever the address filter mode.
// - With 5 to 8 data bits, the first stop bit is the frame type.
// - With nine data bits, the received ninth bit is the frame type.
// - Type bit one means address frame, zero means data frame.
// - In filter mode, address frames are buffered and flag receive complete as normal.
// - Transmitter and receiver share one character size setting.
// - Filter mode bit shares a register with write-one-to-clear transmit complete.
// - Sixteen samples per bit normally, eight in double speed.
// - First vote sample is 8 normally, 4 in double speed.
// - Middle vote sample is 9 normally, 5 in double speed.
// - Data plus parity bits may total 5 to 10.
// - Each end should keep within half the total tolerable rate error.
// - Double speed cuts the divisor from 16 to 8.
package uaf_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CSRA = 8'h00;
   localparam logic [7:0] ADDR_CSRB = 8'h04;
   localparam logic [7:0] ADDR_CSRC = 8'h08;
   localparam logic [7:0] ADDR_BAUD = 8'h0c;
   localparam logic [7:0] ADDR_DATA = 8'h10;
   // Status register a bit positions
   localparam int A_RXC  = 7;
   localparam int A_TXC  = 6;
   localparam int A_DBL  = 1;
   localparam int A_AFM  = 0;
   // Control register b bit positions
   localparam int B_RXEN = 4;
   localparam int B_TXEN = 3;
   localparam int B_SZ2  = 2;
   localparam int B_TB8  = 0;
   // Control register c bit positions
   localparam int C_UPM  = 4;
   localparam int C_USBS = 3;
   localparam int C_SZ   = 1;
   // Reset values
   localparam logic [2:0]  RST_SZ   = 3'h3;
   localparam logic [11:0] RST_BAUD = 12'h000;
   // Character size code for nine data bits
   localparam logic [2:0] SZ_NINE  = 3'h7;
   localparam logic [3:0] MIN_BITS = 4'h5;
   // Sample timing per bit
   localparam logic [4:0] SPB_NORM   = 5'h10;
   localparam logic [4:0] SPB_DBL    = 5'h08;
   localparam logic [4:0] FIRST_NORM = 5'h08;
   localparam logic [4:0] FIRST_DBL  = 5'h04;
   localparam logic [4:0] MID_NORM   = 5'h09;
   localparam logic [4:0] MID_DBL    = 5'h05;
   // Receiver states
   typedef enum logic [1:0] {
      UAF_IDLE  = 2'b00,
      UAF_START = 2'b01,
      UAF_BITS  = 2'b10
   } uaf_rx_e;
endpackage : uaf_pkg

/* core/uaf_rx_mem.sv */
// Two-entry receive buffer storage with registered read data
`timescale 1ns/1ps
module uaf_rx_mem #(
   parameter int W     = 11,
   parameter int DEPTH = 2,
   parameter int AW    = 1
) (
   input  wire logic          clk_in,
   input  wire logic          nrst_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [W-1:0]  wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic [W-1:0]       rdata_out
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0]            rd;
   } uaf_mem_s;

   uaf_mem_s r;
   uaf_mem_s next_r;

   // Write port and registered read of the head entry
   always_comb begin
      next_r = r;
      if (we_in) begin
         next_r.mem[waddr_in] = wdata_in;
      end
      next_r.rd = r.mem[raddr_in];
   end

   // State register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata_out = r.rd;
endmodule : uaf_rx_mem

/* verif/uaf_node.sv */
// Remote serial node model: sends frames to the port and captures what it sends
`timescale 1ns/1ps
module uaf_node (
   input  wire logic clk_in,
   input  wire logic line_in,
   output logic      line_out
);
   // Line idles high between frames
   initial line_out = 1'b1;

   // One bit time, optionally corrupted at its edges, away from the vote samples
   task automatic put(input logic b, input int spb, input int g1, input int g2);
      if (g1 > 0) begin
         line_out <= ~b;
         repeat (g1) @(posedge clk_in);
      end
      line_out <= b;
      repeat (spb - g1 - g2) @(posedge clk_in);
      if (g2 > 0) begin
         line_out <= ~b;
         repeat (g2) @(posedge clk_in);
      end
   endtask : put

   // Idle gap, start, data LSB first, even parity, typed stop, second stop
   task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic st,
                       input int spb, input bit gl, input int gap);
      logic p;
      p = 1'b0;
      repeat (gap) @(posedge clk_in);
      put(1'b0, spb, 0, 0); // Exact bit time, no rate error
      for (int i = 0; i < nb; i++) begin
         p = p ^ d[i];
         put(d[i], spb, gl ? spb / 4 : 0, gl ? spb / 8 : 0); // Ninth bit is type
      end
      if (pen)
         put(p, spb, 0, 0);
      put(st, spb, 0, 0);   // First stop carries type in short formats
      put(1'b1, spb, 0, 0); // Second stop always sent
   endtask : send

   // Capture one frame from the port, sampled mid bit
   task automatic recv(input int nb, input int spb, output logic [8:0] d);
      d = 9'h0;
      while (line_in !== 1'b0) @(posedge clk_in);
      repeat (spb / 2) @(posedge clk_in);
      for (int i = 0; i < nb; i++) begin
         repeat (spb) @(posedge clk_in);
         d[i] = line_in;
      end
   endtask : recv
endmodule : uaf_node

/* verif/testbench.sv */
// Self-checking bench: registers, address filter, sampling and transmit path
`timescale 1ns/1ps
module testbench;
   logic        clk_in;
   logic        nrst_in;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rxd;
   logic        txd;
   logic [31:0] rv;
   logic        re;
   logic [8:0]  d;
   logic [8:0]  got;
   logic [7:0]  fl;
   logic        keep;
   int          mismatches;
   int          n_compared;
   integer      seed;
   int          spb;
   int          nb;

   uaf_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
                .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
                .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
                .rxd_in(rxd), .txd_out(txd));
   uaf_node node (.clk_in(clk_in), .line_in(txd), .line_out(rxd));

   // 50 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task end_of_test;
      $display("Compared %0d values, %0d mismatches", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // One transfer; entered just after a rising edge, waits for ready, watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask : rd

   // Expected status a: buffer empty for transmit always set here
   function automatic logic [31:0] csra(input logic rxc, input logic txc, input logic [7:0] f);
      return {24'h0, rxc, txc, 1'b1, 5'h0} | {24'h0, f};
   endfunction : csra

   // Frame from the node after a random idle gap, then let flags settle
   task automatic frame(input logic [8:0] v, input logic pen, input logic st, input bit gl);
      node.send(v, nb, pen, st, spb, gl, $random(seed) & 32'hf);
      repeat (4) @(posedge clk_in);
   endtask : frame

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_in);
      mismatches++;
      end_of_test;
   end

   // Main sequence
   initial begin
      seed = 81506;
      mismatches = 0;
      n_compared = 0;
      nrst_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      rd(uaf_pkg::ADDR_CSRA);
      check("reset a", rv, 32'h20);
      rd(uaf_pkg::ADDR_CSRB);
      check("reset b", rv, 32'h0);
      rd(uaf_pkg::ADDR_CSRC);
      check("reset c", rv, 32'h6);
      rd(uaf_pkg::ADDR_BAUD);
      check("reset baud", rv, 32'h0);
      rd(8'h14);
      check("unmapped", {31'h0, re}, 32'h1);
      // Nine-bit frames; filter on except on pass six, where this node is addressed
      spb = 16;
      nb  = 9;
      wr(uaf_pkg::ADDR_CSRB, 32'h1c);
      for (int k = 0; k < 10; k++) begin
         fl = {7'h0, k != 6};
         d  = 9'($random(seed));
         if (k < 2 || k == 6)
            d[8] = k[0];
         keep = d[8] | ~fl[0];
         wr(uaf_pkg::ADDR_CSRA, {24'h0, fl});
         frame(d, 1'b0, 1'b1, k[0]);
         rd(uaf_pkg::ADDR_CSRA);
         check("status a", rv, csra(keep, 1'b0, fl));
         if (keep) begin
            rd(uaf_pkg::ADDR_CSRB);
            check("ninth bit", rv, {27'h3, 1'b1, d[8], 1'b0});
            rd(uaf_pkg::ADDR_DATA);
            check("rx data", rv, {24'h0, d[7:0]});
         end
      end
      // Short sizes typed by first stop; nine bits with parity; speeds and divisors varied
      for (int c = 0; c < 5; c++) begin
         fl  = {6'h0, c[0], 1'b1};
         nb  = (c == 4) ? 9 : c + 5;
         spb = (c[0] ? 8 : 16) * (c[1] + 1);
         wr(uaf_pkg::ADDR_BAUD, {31'h0, c[1]});
         wr(uaf_pkg::ADDR_CSRA, {24'h0, fl});
         wr(uaf_pkg::ADDR_CSRB, (c == 4) ? 32'h1c : 32'h18);
         wr(uaf_pkg::ADDR_CSRC, (c == 4) ? 32'h26 : 32'(c) << 1);
         d = 9'($random(seed)) & ((9'h1 << nb) - 9'h1);
         for (int t = 0; t < 2; t++) begin
            if (c == 4)
               d[8] = t[0];
            frame(d, c == 4, t[0] | (c == 4), c[1]);
            rd(uaf_pkg::ADDR_CSRA);
            check("status a", rv, csra(t[0], 1'b0, fl));
         end
         rd(uaf_pkg::ADDR_DATA);
         check("rx data", rv, {24'h0, d[7:0]});
      end
      // Three unread address frames, odd parity expected: bad stop, parity error, overrun
      wr(uaf_pkg::ADDR_CSRC, 32'h36);
      for (int t = 0; t < 3; t++)
         frame(9'h100 | 9'(t), 1'b1, t != 0, 1'b0);
      rd(uaf_pkg::ADDR_CSRA);
      check("error flags", rv, csra(1'b1, 1'b0, 8'h1d));
      rd(uaf_pkg::ADDR_DATA);
      check("first addr", rv, 32'h0);
      rd(uaf_pkg::ADDR_CSRA);
      check("second flags", rv, csra(1'b1, 1'b0, 8'h0d));
      // Disabling the receiver empties the buffer and its flags
      wr(uaf_pkg::ADDR_CSRB, 32'h0c);
      rd(uaf_pkg::ADDR_CSRA);
      check("flushed", rv, csra(1'b0, 1'b0, 8'h01));
      // Transmit path with and without the filter; size shared with receiver
      wr(uaf_pkg::ADDR_BAUD, 32'h0);
      wr(uaf_pkg::ADDR_CSRC, 32'he); // Two stop bits on the transmit side
      spb = 16;
      for (int t = 0; t < 3; t++) begin
         fl   = {7'h0, t != 1};
         d    = 9'($random(seed));
         d[8] = (t != 1); // Stop bit in 8-bit mode, ninth bit otherwise
         wr(uaf_pkg::ADDR_CSRA, {24'h0, fl});
         wr(uaf_pkg::ADDR_CSRB, {27'h3, t > 0, 1'b0, t == 2});
         fork
            node.recv(9, spb, got);
            wr(uaf_pkg::ADDR_DATA, {24'h0, d[7:0]});
         join
         check("tx frame", {23'h0, got}, {23'h0, d});
         repeat (3 * spb) @(posedge clk_in);
         rd(uaf_pkg::ADDR_CSRA);
         check("tx done", rv, csra(1'b0, 1'b1, fl));
         wr(uaf_pkg::ADDR_CSRA, {24'h0, fl} | 32'h40);
         rd(uaf_pkg::ADDR_CSRA);
         check("tx clear", rv, csra(1'b0, 1'b0, fl));
      end
      end_of_test;
   end
endmodule : testbench
